// file: swd_defs.vh
// Constants shared by the switch-detect sleep and wake control files.
`ifndef SWD_DEFS_VH
`define SWD_DEFS_VH

// ==========================================================
// Clock and time base
// ==========================================================
`define SWD_CLK_HZ 20000000
`define SWD_US_CYC (`SWD_CLK_HZ / 1000000)
`define SWD_MS_US 1000
`define SWD_SCAN_WIN_US 125
`define SWD_WET_MS 20
`define SWD_INT_BASE_MS 12'h020
`define SWD_SCAN_BASE_MS 7'h01

// ==========================================================
// Serial word layout
// ==========================================================
`define SWD_FRAME_BITS 24
`define SWD_CMD_MSB 23
`define SWD_CMD_LSB 16
`define SWD_CMD_SLEEP 8'h0C
`define SWD_INT_FLD_MSB 5
`define SWD_INT_FLD_LSB 3
`define SWD_SCAN_FLD_MSB 2
`define SWD_SCAN_FLD_LSB 0
`define SWD_INT_OFF 3'h7
`define SWD_SCAN_OFF 3'h0
`define SWD_SO_THERM 23
`define SWD_SO_INT 22
`define SWD_NUM_IN 22

`endif

// file: swd_mcu_model.sv
// Controller model: serial link master and its side of the interrupt wire.
module swd_mcu_model (
   input wire logic clk_i,
   input wire logic miso_i,
   input wire logic miso_oe_i,
   input wire logic int_oe_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic int_wire_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_n = 1'b1;
   // Open drain with pull-up: low while either side pulls.
   assign int_wire_o = !int_oe_i && pull_n;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b1;
   end
   // ==========
   // Transfers
   // ==========
   // The clock idles low between frames; 200 ns halves keep edges off the sampling edge.
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      @(posedge clk_i);
      #1 cs_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi_o = w[i];
         #200 sclk_o = 1'b1;
         r[i] = miso_oe_i ? miso_i : 1'bx;
         #200 sclk_o = 1'b0;
      end
      #200 cs_n_o = 1'b1;
      mosi_o = !mosi_o;
      #200;
   endtask
   task automatic int_pulse;
      @(posedge clk_i);
      #1 pull_n = 1'b0;
      #400 pull_n = 1'b1;
   endtask
endmodule // swd_mcu_model

// file: swd_sleep_ctrl.v
// Sleep and wake control with scan polling and thermal current fold-back.
`include "swd_defs.vh"
module swd_sleep_ctrl #(
   parameter MS_US = `SWD_MS_US
) (
   input wire clk_i,
   input wire reset_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire mosi_i,
   output wire miso_o,
   output wire miso_oe_o,
   input wire int_n_i,
   output reg int_n_o,
   output reg int_n_oe_o,
   input wire wake_n_i,
   input wire vdd_ok_i,
   input wire therm_hot_i,
   input wire [21:0] sw_i,
   input wire [21:0] wake_en_i,
   input wire [21:0] metallic_i,
   input wire [21:0] wet_tmr_en_i,
   output reg sleep_o,
   output reg inputs_active_o,
   output reg therm_reduce_o,
   output reg [21:0] high_cur_o
);
   // ==========================================================
   // States and declarations
   // ==========================================================
   localparam ST_NORMAL = 3'h1;
   localparam ST_SLEEP = 3'h2;
   localparam ST_SCAN = 3'h4;
   localparam [31:0] WIN_LAST_W = `SWD_SCAN_WIN_US - 1;
   localparam [31:0] WET_LIM_W = `SWD_WET_MS;
   localparam [6:0] WIN_LAST = WIN_LAST_W[6:0];
   localparam [4:0] WET_LIM = WET_LIM_W[4:0];

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg int_m_ff, int_s_ff, int_d_ff;
   reg wk_m_ff, wk_s_ff, wk_d_ff;
   reg vdd_m_ff, vdd_s_ff;
   reg hot_m_ff, hot_s_ff;
   reg [21:0] sw_m_ff, sw_s_ff;
   reg [21:0] sw_ref_ff;
   reg [21:0] pre_ff;
   reg [2:0] int_code_ff;
   reg [2:0] scan_code_ff;
   reg [11:0] int_cnt_ff;
   reg [6:0] scan_cnt_ff;
   reg [6:0] win_cnt_ff;
   reg int_flag_ff;
   reg ev_cs_ff;
   reg therm_flag_ff;
   reg [21:0] nxt_high;

   wire cs_low, cs_fall, cs_rise, frame_vld;
   wire [23:0] frame;
   wire us_tick, ms_tick;

   wire normal = state_ff[0];
   wire asleep = ~state_ff[0];

   // ==========================================================
   // Synchronisers for pins from outside the clock domain
   // ==========================================================
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_m_ff <= 1'b1;
         int_s_ff <= 1'b1;
         int_d_ff <= 1'b1;
         wk_m_ff <= 1'b1;
         wk_s_ff <= 1'b1;
         wk_d_ff <= 1'b1;
         vdd_m_ff <= 1'b0;
         vdd_s_ff <= 1'b0;
         hot_m_ff <= 1'b0;
         hot_s_ff <= 1'b0;
         sw_m_ff <= 22'h00_0000;
         sw_s_ff <= 22'h00_0000;
      end else begin
         int_m_ff <= int_n_i;
         int_s_ff <= int_m_ff;
         int_d_ff <= int_s_ff;
         wk_m_ff <= wake_n_i;
         wk_s_ff <= wk_m_ff;
         wk_d_ff <= wk_s_ff;
         vdd_m_ff <= vdd_ok_i;
         vdd_s_ff <= vdd_m_ff;
         hot_m_ff <= therm_hot_i;
         hot_s_ff <= hot_m_ff;
         sw_m_ff <= sw_i;
         sw_s_ff <= sw_m_ff;
      end
   end

   // ==========================================================
   // Serial port and time base
   // ==========================================================
   // The returned word shows live comparator levels, synchronised every cycle, so they are current after a wake.
   wire [23:0] tx_word = {therm_flag_ff, int_flag_ff, sw_s_ff};

   swd_spi_rx u_spi (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cs_n_i(cs_n_i),
      .sclk_i(sclk_i),
      .mosi_i(mosi_i),
      .tx_word_i(tx_word),
      .miso_o(miso_o),
      .miso_oe_o(miso_oe_o),
      .cs_low_o(cs_low),
      .cs_fall_o(cs_fall),
      .cs_rise_o(cs_rise),
      .frame_vld_o(frame_vld),
      .frame_o(frame)
   );

   swd_tick_div #(.DIV(`SWD_US_CYC), .W(8)) u_us (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clr_i(1'b0),
      .en_i(1'b1),
      .tick_o(us_tick)
   );

   wire sleep_cmd = frame_vld & (frame[`SWD_CMD_MSB:`SWD_CMD_LSB] == `SWD_CMD_SLEEP);
   wire sleep_go = normal & sleep_cmd;

   // Millisecond phase restarts with each sleep so the first period is whole.
   swd_tick_div #(.DIV(MS_US), .W(16)) u_ms (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clr_i(sleep_go),
      .en_i(us_tick),
      .tick_o(ms_tick)
   );

   // ==========================================================
   // Sleep timers
   // ==========================================================
   wire [11:0] int_lim = `SWD_INT_BASE_MS << int_code_ff;
   wire [2:0] scan_sh = scan_code_ff - 3'h1;
   wire [6:0] scan_lim = `SWD_SCAN_BASE_MS << scan_sh;
   wire int_on = (int_code_ff != `SWD_INT_OFF);
   wire scan_on = (scan_code_ff != `SWD_SCAN_OFF);
   wire int_exp = asleep & int_on & ms_tick & (int_cnt_ff == int_lim - 12'h001);
   wire scan_exp = state_ff[1] & scan_on & ms_tick & (scan_cnt_ff == scan_lim - 7'h01);
   wire win_end = state_ff[2] & us_tick & (win_cnt_ff == WIN_LAST);
   wire [21:0] scan_diff = sw_s_ff ^ pre_ff;
   wire scan_wake = win_end & (|scan_diff);
   wire scan_int = win_end & (|(scan_diff & wake_en_i));

   // The millisecond phase runs on across a scan window, so the next scan may come early.
   // Restarting it there would cost the interrupt timer a partial millisecond on every scan.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_code_ff <= `SWD_INT_OFF;
         scan_code_ff <= `SWD_SCAN_OFF;
         int_cnt_ff <= 12'h000;
         scan_cnt_ff <= 7'h00;
         win_cnt_ff <= 7'h00;
         pre_ff <= 22'h00_0000;
      end else begin
         if (sleep_go) begin
            int_code_ff <= frame[`SWD_INT_FLD_MSB:`SWD_INT_FLD_LSB];
            scan_code_ff <= frame[`SWD_SCAN_FLD_MSB:`SWD_SCAN_FLD_LSB];
            pre_ff <= sw_s_ff;
         end
         if (normal) begin
            int_cnt_ff <= 12'h000;
            scan_cnt_ff <= 7'h00;
         end else begin
            if (ms_tick) begin
               int_cnt_ff <= int_cnt_ff + 12'h001;
            end
            if (state_ff[2]) begin
               scan_cnt_ff <= 7'h00;
            end else if (scan_exp) begin
               scan_cnt_ff <= 7'h00;
            end else if (ms_tick) begin
               scan_cnt_ff <= scan_cnt_ff + 7'h01;
            end
         end
         if (!state_ff[2]) begin
            win_cnt_ff <= 7'h00;
         end else if (us_tick) begin
            win_cnt_ff <= win_cnt_ff + 7'h01;
         end
      end
   end

   // ==========================================================
   // Wake sources and mode
   // ==========================================================
   wire wake_fall = wk_d_ff & ~wk_s_ff;
   wire intp_fall = int_d_ff & ~int_s_ff & wk_s_ff & vdd_s_ff;
   wire cs_wake = cs_fall & vdd_s_ff;
   wire wake_any = wake_fall | intp_fall | cs_wake | int_exp;

   // Normal-to-Sleep has one cause and any wake leaves once; later events are moot.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_NORMAL: begin
            if (sleep_go) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_any) begin
               nxt_state = ST_NORMAL;
            end else if (scan_exp) begin
               nxt_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (wake_any | scan_wake) begin
               nxt_state = ST_NORMAL;
            end else if (win_end) begin
               nxt_state = ST_SLEEP;
            end
         end
         default: begin
            nxt_state = ST_NORMAL;
         end
      endcase
   end

   // ==========================================================
   // Interrupt and thermal flags
   // ==========================================================
   wire sw_chg = normal & (|((sw_s_ff ^ sw_ref_ff) & wake_en_i));
   wire therm_set = normal & hot_s_ff & ~therm_flag_ff;
   wire int_set = sw_chg | int_exp | scan_int | therm_set;
   wire int_ack = frame_vld & ~ev_cs_ff;
   wire nxt_int = int_set | (int_flag_ff & ~int_ack);
   wire therm_clr = cs_rise & ~hot_s_ff;
   wire nxt_therm = therm_set | (therm_flag_ff & ~therm_clr);

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= ST_NORMAL;
         sw_ref_ff <= 22'h00_0000;
         int_flag_ff <= 1'b0;
         ev_cs_ff <= 1'b0;
         therm_flag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (normal) begin
            sw_ref_ff <= sw_s_ff;
         end else begin
            sw_ref_ff <= pre_ff;
         end
         int_flag_ff <= nxt_int;
         therm_flag_ff <= nxt_therm;
         // An event while the word is in flight keeps the line low past the read.
         if (int_set & cs_low) begin
            ev_cs_ff <= 1'b1;
         end else if (cs_fall) begin
            ev_cs_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Wetting current control
   // ==========================================================
   // Wetting settings are inputs held elsewhere and never altered here.
   wire nxt_active = ~nxt_state[1];
   wire nxt_reduce = nxt_state[0] & hot_s_ff;

   genvar gi;
   generate
      for (gi = 0; gi < `SWD_NUM_IN; gi = gi + 1) begin : g_wet
         reg [4:0] wet_cnt_ff;
         wire closed = sw_s_ff[gi];
         wire in_win = (wet_cnt_ff < WET_LIM);
         always @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               wet_cnt_ff <= 5'h00;
            end else if (!closed) begin
               wet_cnt_ff <= 5'h00;
            end else if (ms_tick & in_win) begin
               wet_cnt_ff <= wet_cnt_ff + 5'h01;
            end
         end
         always @* begin
            nxt_high[gi] = nxt_active & metallic_i[gi] & closed & ~nxt_reduce
                           & (~wet_tmr_en_i[gi] | in_win);
         end
      end
   endgenerate

   // ==========================================================
   // Registered outputs
   // ==========================================================
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         int_n_o <= 1'b1;
         int_n_oe_o <= 1'b0;
         sleep_o <= 1'b0;
         inputs_active_o <= 1'b1;
         therm_reduce_o <= 1'b0;
         high_cur_o <= 22'h00_0000;
      end else begin
         int_n_o <= ~nxt_int;
         int_n_oe_o <= nxt_int;
         sleep_o <= ~nxt_state[0];
         inputs_active_o <= nxt_active;
         therm_reduce_o <= nxt_reduce;
         high_cur_o <= nxt_high;
      end
   end
endmodule // swd_sleep_ctrl

// file: swd_sleep_ctrl_assertions.sv
// Concurrent checks on the ports of the sleep and wake controller.
module swd_sleep_ctrl_chk #(
   parameter int MS_US = 1000
) (
   input logic clk_i,
   input logic reset_i,
   input logic cs_n_i,
   input logic wake_n_i,
   input logic vdd_ok_i,
   input logic int_n_o,
   input logic int_n_oe_o,
   input logic miso_oe_o,
   input logic sleep_o,
   input logic inputs_active_o,
   input logic therm_reduce_o,
   input logic [21:0] high_cur_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Properties
   // ==========
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_int_oe_pair: assert property (int_n_oe_o == !int_n_o)
      else $error("interrupt drive and level disagree");
   a_int_held: assert property ((cs_n_i && !int_n_o) [*8] |=> !int_n_o)
      else $error("interrupt dropped without a read");
   a_miso_drive: assert property (!cs_n_i [*6] |-> miso_oe_o)
      else $error("serial output not driven in frame");
   a_sleep_by_cmd: assert property ($rose(sleep_o) |-> $past(cs_n_i, 1) && $past(cs_n_i, 3))
      else $error("sleep entered outside a frame end");
   a_wake_pin: assert property (sleep_o && $fell(wake_n_i) |-> ##[1:8] !sleep_o)
      else $error("wake pin fall did not wake");
   a_cs_wake: assert property (sleep_o && vdd_ok_i && $fell(cs_n_i) |-> ##[1:8] !sleep_o)
      else $error("chip select fall did not wake");
   a_idle_no_cur: assert property (!inputs_active_o |-> high_cur_o == 22'h00_0000)
      else $error("current while inputs idle");
   a_sleep_no_therm: assert property (sleep_o |-> !therm_reduce_o)
      else $error("thermal fold-back in sleep");
   a_hot_low_cur: assert property (therm_reduce_o && $past(therm_reduce_o) |-> high_cur_o == 0)
      else $error("high current while hot");
endmodule // swd_sleep_ctrl_chk

bind swd_sleep_ctrl swd_sleep_ctrl_chk #(.MS_US(MS_US)) chk_u (.clk_i(clk_i), .reset_i(reset_i),
   .cs_n_i(cs_n_i), .wake_n_i(wake_n_i), .vdd_ok_i(vdd_ok_i), .int_n_o(int_n_o),
   .int_n_oe_o(int_n_oe_o), .miso_oe_o(miso_oe_o), .sleep_o(sleep_o),
   .inputs_active_o(inputs_active_o), .therm_reduce_o(therm_reduce_o), .high_cur_o(high_cur_o));

// file: swd_spi_rx.v
// Serial port front end: samples the link pins and frames 24-bit words.
`include "swd_defs.vh"
module swd_spi_rx (
   input wire clk_i,
   input wire reset_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire mosi_i,
   input wire [23:0] tx_word_i,
   output reg miso_o,
   output reg miso_oe_o,
   output reg cs_low_o,
   output reg cs_fall_o,
   output reg cs_rise_o,
   output reg frame_vld_o,
   output reg [23:0] frame_o
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   reg cs_m_ff, cs_s_ff, cs_d_ff;
   reg sck_m_ff, sck_s_ff, sck_d_ff;
   reg mo_m_ff, mo_s_ff;
   reg [23:0] rx_ff;
   reg [23:0] tx_ff;
   reg [4:0] cnt_ff;

   wire cs_fall = cs_d_ff & ~cs_s_ff;
   wire cs_rise = ~cs_d_ff & cs_s_ff;
   wire sck_rise = ~sck_d_ff & sck_s_ff & ~cs_s_ff;
   wire sck_fall = sck_d_ff & ~sck_s_ff & ~cs_s_ff;

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_m_ff <= 1'b1;
         cs_s_ff <= 1'b1;
         cs_d_ff <= 1'b1;
         sck_m_ff <= 1'b0;
         sck_s_ff <= 1'b0;
         sck_d_ff <= 1'b0;
         mo_m_ff <= 1'b0;
         mo_s_ff <= 1'b0;
      end else begin
         cs_m_ff <= cs_n_i;
         cs_s_ff <= cs_m_ff;
         cs_d_ff <= cs_s_ff;
         sck_m_ff <= sclk_i;
         sck_s_ff <= sck_m_ff;
         sck_d_ff <= sck_s_ff;
         mo_m_ff <= mosi_i;
         mo_s_ff <= mo_m_ff;
      end
   end

   // ==========================================================
   // Shift registers
   // ==========================================================
   // Only a word of exactly 24 clocks is taken; longer or shorter ones are dropped.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_ff <= 24'h00_0000;
         tx_ff <= 24'h00_0000;
         cnt_ff <= 5'h00;
         miso_o <= 1'b0;
         miso_oe_o <= 1'b0;
         cs_low_o <= 1'b0;
         cs_fall_o <= 1'b0;
         cs_rise_o <= 1'b0;
         frame_vld_o <= 1'b0;
         frame_o <= 24'h00_0000;
      end else begin
         cs_low_o <= ~cs_s_ff;
         cs_fall_o <= cs_fall;
         cs_rise_o <= cs_rise;
         miso_oe_o <= ~cs_s_ff;
         frame_vld_o <= cs_rise & (cnt_ff == `SWD_FRAME_BITS);
         if (cs_rise) begin
            frame_o <= rx_ff;
         end
         if (cs_fall) begin
            cnt_ff <= 5'h00;
            tx_ff <= tx_word_i;
            miso_o <= tx_word_i[23];
         end else begin
            if (sck_rise) begin
               rx_ff <= {rx_ff[22:0], mo_s_ff};
               if (cnt_ff != 5'h1F) begin
                  cnt_ff <= cnt_ff + 5'h01;
               end
            end
            if (sck_fall) begin
               tx_ff <= {tx_ff[22:0], 1'b0};
               miso_o <= tx_ff[22];
            end
         end
      end
   end
endmodule // swd_spi_rx

// file: swd_tick_div.v
// Enable-driven divider that emits a one-cycle tick every DIV enables.
module swd_tick_div #(
   parameter DIV = 20,
   parameter W = 16
) (
   input wire clk_i,
   input wire reset_i,
   input wire clr_i,
   input wire en_i,
   output reg tick_o
);
   reg [W-1:0] cnt_ff;
   wire last = (cnt_ff == DIV - 1);

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (clr_i) begin
         cnt_ff <= {W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= en_i & last;
         if (en_i) begin
            cnt_ff <= last ? {W{1'b0}} : cnt_ff + 1'b1;
         end
      end
   end
endmodule // swd_tick_div

// file: tb.sv
// Self-checking bench for the switch-detect sleep and wake controller.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MSU = 10;
   localparam int MSC = MSU * 20;
   logic clk_i = 0, reset_i = 1, cs_n, sclk, mosi, miso, miso_oe, int_w, int_n, int_oe;
   logic wake_n = 1, vdd = 1, hot = 0, sleep, act, red;
   logic [21:0] sw = 0, wen = '1, met = 0, wten = '1, hc;
   logic [23:0] rd;
   int mismatches = 0, total_checks = 0, waited;
   always #25 clk_i = !clk_i;
   swd_sleep_ctrl #(.MS_US(MSU)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
      .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .int_n_i(int_w),
      .int_n_o(int_n), .int_n_oe_o(int_oe), .wake_n_i(wake_n), .vdd_ok_i(vdd),
      .therm_hot_i(hot), .sw_i(sw), .wake_en_i(wen), .metallic_i(met), .wet_tmr_en_i(wten),
      .sleep_o(sleep), .inputs_active_o(act), .therm_reduce_o(red), .high_cur_o(hc));
   swd_mcu_model mcu_u (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe), .int_oe_i(int_oe),
      .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .int_wire_o(int_w));
   // ==========
   // Helpers
   // ==========
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   function automatic logic sg(input int k);
      return k == 0 ? sleep : k == 1 ? act : int_oe;
   endfunction
   // Bounded wait; running out ends the run at once.
   task automatic wt(input int k, input logic v, input int n);
      for (waited = 0; waited < n && sg(k) !== v; waited++) cyc(1);
      if (sg(k) !== v) begin
         chk(1'b0, "wait ran out");
         finish_test();
      end
   endtask
   task automatic slp(input logic [5:0] f);
      mcu_u.xfer({8'h0C, 10'h000, f}, rd);
      wt(0, 1'b1, 10);
   endtask
   // ==========
   // Scenarios
   // ==========
   task automatic s_ack;
      sw[3] = 1'b1;
      wt(2, 1'b1, 10);
      cyc(100);
      chk(int_oe === 1'b1, "interrupt not held");
      mcu_u.xfer(24'h00_0000, rd);
      chk(rd[21:0] === sw && rd[22] === 1'b1, "status word");
      cyc(6);
      chk(int_oe === 1'b0, "read did not clear");
      fork
         mcu_u.xfer(24'h00_0000, rd);
         begin
            cyc(50);
            sw[4] = 1'b1;
         end
      join
      cyc(6);
      chk(int_oe === 1'b1, "event in frame was cleared");
      mcu_u.xfer(24'h00_0000, rd);
      cyc(2);
      chk(int_oe === 1'b0 && rd[21:0] === sw, "second read");
      wen[5] = 1'b0;
      sw[5] = 1'b1;
      cyc(10);
      chk(int_oe === 1'b0, "disabled input interrupted");
      mcu_u.xfer(24'h0F_003F, rd);
      cyc(10);
      chk(sleep === 1'b0, "slept on other command");
   endtask
   task automatic s_wake;
      slp(6'o70);
      chk(act === 1'b0, "inputs active in sleep");
      cyc(2000);
      chk(sleep === 1'b1, "woke with timers off");
      wake_n = 1'b0;
      wt(0, 1'b0, 10);
      wake_n = 1'b1;
      chk(act === 1'b1, "inputs idle after wake");
   endtask
   task automatic s_int_timer;
      for (int c = 0; c < 2; c++) begin
         slp({c[2:0], 3'o0});
         wt(0, 1'b0, (32 << c) * MSC + 300);
         chk(waited > (32 << c) * MSC - 300, "timer wake early");
         chk(int_oe === 1'b1, "no timer interrupt");
         mcu_u.xfer(24'h00_0000, rd);
      end
   endtask
   task automatic s_scan;
      for (int c = 1; c < 3; c++) begin
         slp({3'o7, c[2:0]});
         wt(1, 1'b1, (MSC << (c - 1)) + 100);
         chk(waited > (MSC << (c - 1)) - 100, "scan early");
         wt(1, 1'b0, 2600);
         chk(waited > 2400 && sleep === 1'b1, "scan window");
         wt(1, 1'b1, (MSC << (c - 1)) + 100);
         sw[7] = !sw[7];
         wt(0, 1'b0, (MSC << (c - 1)) + 2800);
         chk(int_oe === 1'b1, "no scan interrupt");
         mcu_u.xfer(24'h00_0000, rd);
      end
   endtask
   task automatic s_cs_wake;
      slp(6'o70);
      vdd = 1'b0;
      mcu_u.xfer(24'h00_0000, rd);
      mcu_u.int_pulse();
      cyc(10);
      chk(sleep === 1'b1, "woke without supply");
      vdd = 1'b1;
      mcu_u.xfer(24'h00_0000, rd);
      chk(sleep === 1'b0, "chip select did not wake");
      mcu_u.xfer(24'h00_0000, rd);
      chk(rd[21:0] === sw, "word after wake");
      slp(6'o70);
      mcu_u.int_pulse();
      wt(0, 1'b0, 20);
   endtask
   task automatic s_therm;
      hot = 1'b1;
      wt(2, 1'b1, 10);
      chk(red === 1'b1, "no fold-back");
      mcu_u.xfer(24'h00_0000, rd);
      chk(rd[23] === 1'b1, "flag clear while hot");
      hot = 1'b0;
      cyc(5);
      chk(red === 1'b0, "fold-back kept when cool");
      mcu_u.xfer(24'h00_0000, rd);
      mcu_u.xfer(24'h00_0000, rd);
      chk(rd[23] === 1'b0, "flag not cleared");
      slp(6'o70);
      hot = 1'b1;
      cyc(20);
      chk(red === 1'b0 && int_oe === 1'b0, "thermal active in sleep");
      hot = 1'b0;
      wake_n = 1'b0;
      wt(0, 1'b0, 10);
      wake_n = 1'b1;
   endtask
   task automatic s_wet;
      met = '1;
      wten[9] = 1'b0;
      sw[2] = 1'b1;
      sw[9] = 1'b1;
      cyc(10);
      chk(hc[2] === 1'b1 && hc[9] === 1'b1, "no wetting current");
      cyc(18 * MSC);
      chk(hc[2] === 1'b1, "wetting ended early");
      cyc(3 * MSC);
      chk(hc[2] === 1'b0 && hc[9] === 1'b1, "wetting timer");
      hot = 1'b1;
      cyc(5);
      chk(red === 1'b1 && hc[9] === 1'b0, "high current kept while hot");
      hot = 1'b0;
      cyc(5);
      chk(red === 1'b0 && hc[9] === 1'b1, "current not restored");
   endtask
   initial begin
      cyc(20);
      chk(int_n === 1'b1 && sleep === 1'b0 && act === 1'b1 && hc === 0, "reset state");
      reset_i = 1'b0;
      cyc(5);
      s_ack();
      s_wake();
      s_int_timer();
      s_scan();
      s_cs_wake();
      s_therm();
      s_wet();
      finish_test();
   end
endmodule // tb
